// file: qctl_pkg.sv
package qctl_pkg;
    // =========================================================
    // Host address map
    localparam logic [9:0]  DMA_CTRL_ADDR   = 10'h100;
    localparam logic [9:0]  SNOOP_BASE      = 10'h300;
    localparam logic [9:0]  SNOOP_SEL_ADDR  = 10'h104;
    localparam logic [9:0]  WMARK_ADDR      = 10'h108;
    localparam logic [9:0]  IRQ_FLAGS_ADDR  = 10'h10C;
    localparam logic [9:0]  FREE_CNT_ADDR   = 10'h110;
    localparam logic [9:0]  QSTAT_BASE      = 10'h120;
    localparam logic [9:0]  TX_DATA_BASE    = 10'h140;
    localparam logic [9:0]  RX_DATA_ADDR    = 10'h150;
    // =========================================================
    // Field positions
    localparam int          MODE_HI         = 25;
    localparam int          MODE_LO         = 24;
    localparam int          DMA_RD_BIT      = 17;
    localparam int          DMA_WR_BIT      = 16;
    localparam int          READY_BIT       = 31;
    localparam int          THR_W           = 8;
    localparam logic [1:0]  MODE_RESET      = 2'h0;
    localparam logic [1:0]  MODE_ANY        = 2'h0;
    localparam logic [1:0]  MODE_THR        = 2'h1;
    localparam logic [1:0]  MODE_EOF        = 2'h2;
    localparam logic [1:0]  MODE_EITHER     = 2'h3;
    // Interrupt flag bits
    localparam int          IRQ_WMARK_BIT   = 0;
    localparam int          IRQ_UNDERRUN_BIT = 1;
    localparam int          IRQ_THR_BIT     = 2;
    localparam int          PAUSE_QUEUE     = 0;
    localparam int          NUM_TXQ         = 4;
    localparam int          SNOOP_WORDS     = 64;
    localparam int          NUM_BLOCKS      = 16;
    localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
endpackage

// file: qctl_if.sv
`timescale 1ns/100ps
interface qctl_if;
    logic [9:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        irq;
    modport device (input addr, input wdata, input wr, input rd, output rdata, output irq);
    modport host   (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface

// file: qctl_txq.sv
`timescale 1ns/100ps
module qctl_txq (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rst,
    // Policy and counts
    input  wire logic [1:0]                   mode,
    input  wire logic [qctl_pkg::THR_W-1:0]   threshold,
    input  wire logic [qctl_pkg::THR_W-1:0]   blocks,
    input  wire logic                         has_eof,
    input  wire logic                         force_ready,
    // Results
    output logic                              data_ready,
    output logic                              below_thr_evt
);
    import qctl_pkg::*;
    typedef struct packed {
        logic below;
    } txq_state_t;
    txq_state_t s_q;
    txq_state_t s_d;
    logic above;
    always_comb begin
        s_d = s_q;
        // =====================================================
        // every cycle compare
        above = blocks > threshold;
        s_d.below = blocks < threshold;
        data_ready = 1'b0;
        case (mode)
            MODE_ANY:    data_ready = blocks != '0;
            MODE_THR:    data_ready = above;
            MODE_EOF:    data_ready = has_eof;
            MODE_EITHER: data_ready = has_eof | above;
            default:     data_ready = 1'b0;
        endcase
        if (force_ready) begin
            data_ready = 1'b1;
        end
        below_thr_evt = s_d.below & ~s_q.below;
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// file: qctl_device.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
// Functional notes
// - Two-bit ready policy in bits 25:24
// - Policy 00: ready with any block
// - Policy 01: ready above threshold
// - Policy 10: ready with complete frame
// - Policy 11: frame or above threshold
// - Starved transmit aborts with under-run
// - Interrupt when blocks drop below threshold
// - DMA mode ignores host address
// - DMA control at 0x100, bits 9:0 target
// - Read mode bit 17 redirects reads
// - Read mode ends on writing zero
// - Write mode bit 16 redirects writes
// - Write mode ends on reading control register
// - Data path unchanged during DMA
// - Host transfers words in order
// - Snoop window 0x300-0x3FF maps block
// - Snoop access leaves queue state
// - Interrupt watermark sets flag
// - Pause watermark readies pause queue
// - Headroom watermark halts receiver
// - Halt released above headroom watermark
// - Pause queue is static queue 0
module qctl_device #(
    parameter int NQ = qctl_pkg::NUM_TXQ
) (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // Host bus
    qctl_if.device                          bus,
    // Memory and queue side
    input  wire logic [qctl_pkg::THR_W-1:0] free_blocks,
    input  wire logic [qctl_pkg::THR_W*qctl_pkg::NUM_TXQ-1:0] q_blocks,
    input  wire logic [qctl_pkg::NUM_TXQ-1:0] q_has_eof,
    input  wire logic [qctl_pkg::NUM_TXQ-1:0] q_tx_active,
    input  wire logic [qctl_pkg::NUM_TXQ-1:0] q_tx_starved,
    input  wire logic                       rx_frame_busy,
    // Data path
    output logic                            tx_data_valid,
    output logic [1:0]                      tx_data_queue,
    output logic [31:0]                     tx_data_word,
    output logic                            rx_data_pop,
    input  wire logic [31:0]                rx_data_word,
    // Status out
    output logic [qctl_pkg::NUM_TXQ-1:0]    queue_data_ready,
    output logic                            rx_halt,
    output logic [qctl_pkg::NUM_TXQ-1:0]    tx_underrun
);
    import qctl_pkg::*;
    typedef struct packed {
        logic [9:0]  dma_target;
        logic        dma_rd;
        logic        dma_wr;
        logic [3:0]  snoop_sel;
        logic [7:0]  wm_irq;
        logic [7:0]  wm_pause;
        logic [7:0]  wm_head;
        logic [2:0]  irq_flags;
        logic [7:0]  irq_mask;
        logic        halt;
        logic [NQ*2-1:0]     modes;
        logic [NQ*THR_W-1:0] thrs;
        logic [NQ-1:0]       ur;
        logic        tx_v;
        logic [1:0]  tx_q;
        logic [31:0] tx_w;
        logic        rx_p;
        logic [31:0] rdata;
    } dev_state_t;
    dev_state_t s_q;
    dev_state_t s_d;
    logic [31:0] snoop_mem [SNOOP_WORDS*NUM_BLOCKS];
    logic [NQ-1:0] rdy;
    logic [NQ-1:0] thr_evt;
    logic          pause_hit;
    logic [9:0]    eff_addr;
    logic          snoop_hit;
    logic [9:0]    snoop_idx;
    // =========================================================
    // Per-queue ready logic
    genvar g;
    generate
        for (g = 0; g < NQ; g++) begin : g_q
            qctl_txq u_q (
                .core_clk      (core_clk),
                .rst           (rst),
                .mode          (s_q.modes[g*2 +: 2]),
                .threshold     (s_q.thrs[g*THR_W +: THR_W]),
                .blocks        (q_blocks[g*THR_W +: THR_W]),
                .has_eof       (q_has_eof[g]),
                .force_ready   (g == PAUSE_QUEUE ? pause_hit : 1'b0),
                .data_ready    (rdy[g]),
                .below_thr_evt (thr_evt[g])
            );
        end
    endgenerate
    assign pause_hit = (s_q.wm_pause != '0) && (free_blocks < s_q.wm_pause);
    assign eff_addr = (s_q.dma_rd | s_q.dma_wr) ? s_q.dma_target : bus.addr;
    assign snoop_hit = bus.addr[9:8] == SNOOP_BASE[9:8] && !(s_q.dma_rd | s_q.dma_wr);
    assign snoop_idx = {s_q.snoop_sel, bus.addr[7:2]};
    always_comb begin
        s_d = s_q;
        s_d.tx_v = 1'b0;
        s_d.rx_p = 1'b0;
        s_d.rdata = RESET_WORD;
        // =====================================================
        // headroom halt after frame
        if (s_q.wm_head != '0 && free_blocks < s_q.wm_head && !rx_frame_busy) begin
            s_d.halt = 1'b1;
        end else if (s_q.wm_head == '0 || free_blocks > s_q.wm_head) begin
            s_d.halt = 1'b0;
        end
        // =====================================================
        // Host writes
        if (bus.wr) begin
            if (!(s_q.dma_rd | s_q.dma_wr) && bus.addr == DMA_CTRL_ADDR) begin
                s_d.dma_target = bus.wdata[9:0];
                s_d.dma_rd = bus.wdata[DMA_RD_BIT];
                s_d.dma_wr = bus.wdata[DMA_WR_BIT];
            end else if (s_q.dma_rd && bus.addr == DMA_CTRL_ADDR && !bus.wdata[DMA_RD_BIT]) begin
                s_d.dma_rd = 1'b0;
            end else if (snoop_hit) begin
            end else if (eff_addr == SNOOP_SEL_ADDR) begin
                s_d.snoop_sel = bus.wdata[3:0];
            end else if (eff_addr == WMARK_ADDR) begin
                s_d.wm_irq = bus.wdata[7:0];
                s_d.wm_pause = bus.wdata[15:8];
                s_d.wm_head = bus.wdata[23:16];
            end else if (eff_addr == IRQ_FLAGS_ADDR) begin
                s_d.irq_flags = s_d.irq_flags & ~bus.wdata[2:0];
                s_d.irq_mask = bus.wdata[15:8];
            end else if (eff_addr[9:4] == QSTAT_BASE[9:4] && eff_addr[3:2] < NQ) begin
                s_d.modes[eff_addr[3:2]*2 +: 2] = bus.wdata[MODE_HI:MODE_LO];
                s_d.thrs[eff_addr[3:2]*THR_W +: THR_W] = bus.wdata[THR_W-1:0];
            end else if (eff_addr[9:4] == TX_DATA_BASE[9:4]) begin
                s_d.tx_v = 1'b1;
                s_d.tx_q = eff_addr[3:2];
                s_d.tx_w = bus.wdata;
            end
        end
        // =====================================================
        // Host reads
        if (bus.rd) begin
            if (s_q.dma_rd) begin
                s_d.rx_p = s_q.dma_target == RX_DATA_ADDR;
                s_d.rdata = rx_data_word;
            end else if (bus.addr == DMA_CTRL_ADDR) begin
                s_d.rdata = {14'h0000, s_q.dma_rd, s_q.dma_wr, 6'h00, s_q.dma_target};
                s_d.dma_wr = 1'b0;
            end else if (s_q.dma_wr) begin
                s_d.rdata = RESET_WORD;
            end else if (snoop_hit) begin
                s_d.rdata = snoop_mem[snoop_idx];
            end else if (bus.addr == SNOOP_SEL_ADDR) begin
                s_d.rdata = {28'h0000000, s_q.snoop_sel};
            end else if (bus.addr == WMARK_ADDR) begin
                s_d.rdata = {8'h00, s_q.wm_head, s_q.wm_pause, s_q.wm_irq};
            end else if (bus.addr == IRQ_FLAGS_ADDR) begin
                s_d.rdata = {16'h0000, s_q.irq_mask, 5'h00, s_q.irq_flags};
            end else if (bus.addr == FREE_CNT_ADDR) begin
                s_d.rdata = {24'h000000, free_blocks};
            end else if (bus.addr[9:4] == QSTAT_BASE[9:4] && bus.addr[3:2] < NQ) begin
                s_d.rdata = {rdy[bus.addr[3:2]], 5'h00, s_q.modes[bus.addr[3:2]*2 +: 2],
                             16'h0000, s_q.thrs[bus.addr[3:2]*THR_W +: THR_W]};
            end else if (bus.addr == RX_DATA_ADDR) begin
                s_d.rx_p = 1'b1;
                s_d.rdata = rx_data_word;
            end
        end
        if (s_q.wm_irq != '0 && free_blocks < s_q.wm_irq) begin
            s_d.irq_flags[IRQ_WMARK_BIT] = 1'b1;
        end
        s_d.ur = q_tx_active & q_tx_starved;
        if (|s_d.ur) begin
            s_d.irq_flags[IRQ_UNDERRUN_BIT] = 1'b1;
        end
        if (|thr_evt) begin
            s_d.irq_flags[IRQ_THR_BIT] = 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // Snoop storage write
    always_ff @(posedge core_clk) begin
        if (bus.wr && snoop_hit) begin
            snoop_mem[snoop_idx] <= bus.wdata;
        end
    end
    assign bus.rdata = s_q.rdata;
    assign bus.irq = |(s_q.irq_flags & s_q.irq_mask[2:0]);
    assign queue_data_ready = rdy;
    assign rx_halt = s_q.halt;
    assign tx_underrun = s_q.ur;
    assign tx_data_valid = s_q.tx_v;
    assign tx_data_queue = s_q.tx_q;
    assign tx_data_word = s_q.tx_w;
    assign rx_data_pop = s_q.rx_p;
endmodule

// file: qctl_host.sv
`timescale 1ns/100ps
module qctl_host (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Device bus
    qctl_if.host             bus,
    // User command port
    input  wire logic [9:0]  cmd_addr,
    input  wire logic [31:0] cmd_wdata,
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    output logic [31:0]      cmd_rdata,
    output logic             cmd_irq
);
    import qctl_pkg::*;
    typedef struct packed {
        logic [9:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
        logic [31:0] rdata;
        logic        rd_pend;
    } host_state_t;
    host_state_t s_q;
    host_state_t s_d;
    always_comb begin
        s_d = s_q;
        s_d.wr = cmd_wr;
        s_d.rd = cmd_rd & ~cmd_wr;
        s_d.addr = cmd_addr;
        s_d.wdata = cmd_wdata;
        s_d.rd_pend = s_q.rd;
        if (s_q.rd_pend) begin
            s_d.rdata = bus.rdata;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign bus.addr = s_q.addr;
    assign bus.wdata = s_q.wdata;
    assign bus.wr = s_q.wr;
    assign bus.rd = s_q.rd;
    assign cmd_rdata = s_q.rdata;
    assign cmd_irq = bus.irq;
endmodule

// file: qctl_checker.sv
`timescale 1ns/100ps
module qctl_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // Host bus
    input wire logic [9:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    // Device side
    input wire logic [7:0]  free_blocks,
    input wire logic        rx_frame_busy,
    input wire logic        rx_halt,
    input wire logic        rx_data_pop,
    input wire logic        tx_data_valid,
    input wire logic [1:0]  tx_data_queue,
    input wire logic [31:0] tx_data_word
);
    import qctl_pkg::*;
    // ==============================================
    // Mode and watermark tracking
    logic       rmode_q;
    logic       wmode_q;
    logic [7:0] head_q;
    logic       norm;
    assign norm = !rmode_q && !wmode_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rmode_q <= 1'b0;
            wmode_q <= 1'b0;
            head_q  <= 8'h00;
        end else if (wr && addr == DMA_CTRL_ADDR && !wmode_q && !(rmode_q && wdata[17])) begin
            rmode_q <= wdata[17] && wdata[9:0] == RX_DATA_ADDR;
            wmode_q <= wdata[16] && wdata[9:0] == (TX_DATA_BASE + 10'h004);
        end else if (rd && addr == DMA_CTRL_ADDR && wmode_q) begin
            wmode_q <= 1'b0;
        end else if (wr && addr == WMARK_ADDR && norm) begin
            head_q <= wdata[23:16];
        end
    end
    // ==============================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_ctrl_back;
        wr && addr == DMA_CTRL_ADDR && !wdata[17] && norm ##1 !wr ##1 rd && addr == DMA_CTRL_ADDR;
    endsequence
    sequence s_snoop_back;
        wr && addr[9:8] == 2'h3 && norm ##1 !wr ##1 rd && addr == $past(addr, 2);
    endsequence
    sequence s_wr_end;
        rd && addr == DMA_CTRL_ADDR && wmode_q ##[1:4] wr && addr == TX_DATA_BASE;
    endsequence
    AST_CTRL_READBACK: assert property (s_ctrl_back |=> rdata[9:0] == $past(wdata[9:0], 3))
        else $error("control readback wrong");
    AST_SNOOP_READBACK: assert property (s_snoop_back |=> rdata == $past(wdata, 3))
        else $error("snoop readback wrong");
    AST_RD_REDIRECT: assert property (rmode_q && rd |=> rx_data_pop)
        else $error("read not redirected");
    AST_RD_NORMAL: assert property (!rmode_q && rd && addr != RX_DATA_ADDR |=> !rx_data_pop)
        else $error("pop outside read mode");
    AST_WR_REDIRECT: assert property (wmode_q && wr && addr != DMA_CTRL_ADDR |=>
        tx_data_valid && tx_data_queue == 2'h1 && tx_data_word == $past(wdata))
        else $error("write not redirected");
    AST_WR_READ_ZERO: assert property (wmode_q && rd && addr != DMA_CTRL_ADDR |=> rdata == 32'h0)
        else $error("read in write mode not zero");
    AST_WR_END: assert property (s_wr_end |=> tx_data_valid && tx_data_queue == 2'h0)
        else $error("decoding not restored");
    AST_HALT_SET: assert property (head_q != 8'h00 && free_blocks < head_q && !rx_frame_busy
        |-> ##[0:2] rx_halt)
        else $error("receiver not halted");
    AST_HALT_CLEAR: assert property ((free_blocks > head_q) [*3] |-> !rx_halt)
        else $error("halt not released");
    AST_HALT_OFF: assert property ((head_q == 8'h00) [*3] |-> !rx_halt)
        else $error("halt while disabled");
endmodule

// file: queue_ready_dma_snoop_watermark_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module queue_ready_dma_snoop_watermark_test;
    import qctl_pkg::*;
    // ==============================================
    // Signals
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  cmd_addr = 10'h000;
    logic [31:0] cmd_wdata = 32'h0;
    logic        cmd_wr = 1'b0;
    logic        cmd_rd = 1'b0;
    logic [31:0] cmd_rdata;
    logic        cmd_irq;
    logic [7:0]  free_blocks = 8'h10;
    logic [31:0] q_blocks = 32'h0;
    logic [3:0]  q_has_eof = 4'h0;
    logic [3:0]  q_tx_active = 4'h0;
    logic [3:0]  q_tx_starved = 4'h0;
    logic        rx_frame_busy = 1'b0;
    logic [31:0] rx_data_word = 32'hCAFE_0001;
    logic        tx_data_valid;
    logic [1:0]  tx_data_queue;
    logic [31:0] tx_data_word;
    logic        rx_data_pop;
    logic [3:0]  queue_data_ready;
    logic        rx_halt;
    logic [3:0]  tx_underrun;
    logic [31:0] rv;
    logic [33:0] txlog[$];
    logic [7:0]  cb[5] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h01};
    logic        ce[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [33:0] tx_exp[3] = '{{2'h1, 32'hA5A5_0001}, {2'h1, 32'hA5A5_0002}, {2'h0, 32'hA5A5_0003}};
    int          n_errors = 0;
    int          check_count = 0;
    int          pops = 0;
    // ==============================================
    // Design, interface and checker
    qctl_if bus_if ();
    qctl_device i_qctl_device (.core_clk(core_clk), .rst(rst), .bus(bus_if),
        .free_blocks(free_blocks), .q_blocks(q_blocks), .q_has_eof(q_has_eof),
        .q_tx_active(q_tx_active), .q_tx_starved(q_tx_starved), .rx_frame_busy(rx_frame_busy),
        .tx_data_valid(tx_data_valid), .tx_data_queue(tx_data_queue), .tx_data_word(tx_data_word),
        .rx_data_pop(rx_data_pop), .rx_data_word(rx_data_word),
        .queue_data_ready(queue_data_ready), .rx_halt(rx_halt), .tx_underrun(tx_underrun));
    qctl_host i_qctl_host (.core_clk(core_clk), .rst(rst), .bus(bus_if), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
        .cmd_irq(cmd_irq));
    qctl_checker i_qctl_checker (.core_clk(core_clk), .rst(rst), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
        .free_blocks(free_blocks), .rx_frame_busy(rx_frame_busy), .rx_halt(rx_halt),
        .rx_data_pop(rx_data_pop), .tx_data_valid(tx_data_valid),
        .tx_data_queue(tx_data_queue), .tx_data_word(tx_data_word));
    // ==============================================
    // Clock and data path monitor
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (tx_data_valid === 1'b1) begin
            txlog.push_back({tx_data_queue, tx_data_word});
        end
        if (rx_data_pop === 1'b1) begin
            pops++;
        end
    end
    // ==============================================
    // Tasks
    task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cmd_addr  <= a;
        cmd_wdata <= d;
        cmd_wr    <= 1'b1;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [9:0] a);
        @(posedge core_clk);
        cmd_addr <= a;
        cmd_rd   <= 1'b1;
        @(posedge core_clk);
        cmd_rd <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rv = cmd_rdata;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    function automatic logic exp_rdy(input int m, input logic [7:0] b, input logic e);
        case (m)
            0: return b != 8'h00;
            1: return b > 8'h03;
            2: return e;
            default: return e || b > 8'h03;
        endcase
    endfunction
    task automatic conclude;
        $display("Counts: %0d checks, %0d errors", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
    // ==============================================
    // Tests
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd_reg(QSTAT_BASE + 10'h004);
        `CHK(rv, 32'h0)
        rd_reg(10'h0FC);
        `CHK(rv, 32'h0)
        wr_reg(DMA_CTRL_ADDR, 32'h0000_0155);
        rd_reg(DMA_CTRL_ADDR);
        `CHK(rv, 32'h0000_0155)
        $display("Test reset done");
        for (int m = 0; m < 4; m++) begin
            wr_reg(QSTAT_BASE + 10'h004, {6'h00, m[1:0], 24'h000003});
            rd_reg(QSTAT_BASE + 10'h004);
            `CHK({rv[25:24], rv[7:0]}, {m[1:0], 8'h03})
            for (int c = 0; c < 5; c++) begin
                @(posedge core_clk);
                q_blocks  <= {16'h0, cb[c], 8'h00};
                q_has_eof <= {2'b00, ce[c], 1'b0};
                tick(1);
                `CHK(queue_data_ready[1], exp_rdy(m, cb[c], ce[c]))
            end
        end
        @(posedge core_clk);
        q_blocks  <= 32'h0000_0400;
        q_has_eof <= 4'h0;
        wr_reg(IRQ_FLAGS_ADDR, 32'h0000_0407);
        @(posedge core_clk);
        q_blocks <= 32'h0000_0200;
        for (int i = 0; i < 8 && cmd_irq !== 1'b1; i++) tick(1);
        `CHK(cmd_irq, 1'b1)
        rd_reg(IRQ_FLAGS_ADDR);
        `CHK(rv[2], 1'b1)
        wr_reg(IRQ_FLAGS_ADDR, 32'h0000_0007);
        tick(3);
        `CHK(cmd_irq, 1'b0)
        @(posedge core_clk);
        q_tx_active  <= 4'h2;
        q_tx_starved <= 4'h2;
        tick(2);
        `CHK(tx_underrun, 4'h2)
        @(posedge core_clk);
        q_tx_active  <= 4'h0;
        q_tx_starved <= 4'h0;
        $display("Test ready policy done");
        wr_reg(WMARK_ADDR, 32'h0004_0608);
        @(posedge core_clk);
        free_blocks   <= 8'h05;
        rx_frame_busy <= 1'b1;
        tick(3);
        `CHK(queue_data_ready[0], 1'b1)
        rd_reg(IRQ_FLAGS_ADDR);
        `CHK(rv[0], 1'b1)
        @(posedge core_clk);
        free_blocks <= 8'h03;
        tick(3);
        `CHK(rx_halt, 1'b0)
        @(posedge core_clk);
        rx_frame_busy <= 1'b0;
        tick(3);
        `CHK(rx_halt, 1'b1)
        @(posedge core_clk);
        free_blocks <= 8'h04;
        tick(3);
        `CHK(rx_halt, 1'b1)
        @(posedge core_clk);
        free_blocks <= 8'h05;
        tick(3);
        `CHK(rx_halt, 1'b0)
        wr_reg(WMARK_ADDR, 32'h0);
        wr_reg(IRQ_FLAGS_ADDR, 32'h0000_0007);
        @(posedge core_clk);
        free_blocks <= 8'h00;
        tick(3);
        `CHK({rx_halt, queue_data_ready[0]}, 2'b00)
        rd_reg(IRQ_FLAGS_ADDR);
        `CHK(rv[0], 1'b0)
        @(posedge core_clk);
        free_blocks <= 8'h10;
        $display("Test watermark done");
        wr_reg(DMA_CTRL_ADDR, 32'h0001_0144);
        wr_reg(10'h000, 32'hA5A5_0001);
        wr_reg(SNOOP_BASE, 32'hA5A5_0002);
        rd_reg(FREE_CNT_ADDR);
        `CHK(rv, 32'h0)
        rd_reg(DMA_CTRL_ADDR);
        `CHK(rv[16], 1'b1)
        wr_reg(TX_DATA_BASE, 32'hA5A5_0003);
        tick(3);
        `CHK(txlog.size(), 3)
        for (int i = 0; i < 3; i++) `CHK(txlog[i], tx_exp[i])
        wr_reg(DMA_CTRL_ADDR, 32'h0002_0150);
        rd_reg(FREE_CNT_ADDR);
        `CHK(rv, 32'hCAFE_0001)
        wr_reg(WMARK_ADDR, 32'h0000_0001);
        rd_reg(DMA_CTRL_ADDR);
        `CHK(rv, 32'hCAFE_0001)
        wr_reg(DMA_CTRL_ADDR, 32'h0000_0150);
        rd_reg(FREE_CNT_ADDR);
        `CHK(rv, 32'h0000_0010)
        rd_reg(WMARK_ADDR);
        `CHK(rv, 32'h0)
        `CHK(pops, 2)
        $display("Test dma done");
        @(posedge core_clk);
        q_has_eof <= 4'h2;
        wr_reg(SNOOP_SEL_ADDR, 32'h0000_0002);
        wr_reg(SNOOP_BASE + 10'h008, 32'h1234_5678);
        rd_reg(SNOOP_BASE + 10'h008);
        `CHK(rv, 32'h1234_5678)
        `CHK(queue_data_ready, 4'h2)
        $display("Test snoop done");
        conclude();
    end
endmodule
